// ---- design/adc_avg_pkg.sv ----
// constants, types and helpers shared by the converter averaging and scaling logic
// Functional notes
// - take one sample per enabled channel every millisecond, 1000 samples per second.
// - each raw sample is an unsigned 10-bit code.
// - enable code 12 enables both, 1 only first, 2 only second.
// - enable code 0 disables both channels; this is the reset state.
// - output full scale is 1023 times the factor, fraction truncated.
// - first channel factor is non-zero and resets to one.
// - second channel has its own factor, resetting to one.
// - each channel averages 1 to 1000 consecutive 1 ms samples.
// - averaging count of each channel resets to sixteen.
// - changing the averaging count never changes the sample rate.
// - every setting is written on its own without touching the others.
package adc_avg_pkg;
   localparam int CLK_HZ      = 100_000_000;
   localparam int SAMPLE_HZ   = 1000;
   localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int CODE_W      = 10;
   localparam int AVG_W       = 10;
   localparam int SUM_W       = 20;
   localparam int SCALE_W     = 16;
   localparam int SCALE_FRAC  = 8;
   localparam int RES_W       = 18;
   localparam int EN_W        = 8;
   localparam int STEP_W      = 5;
   localparam int FIFO_DEPTH  = 8;
   localparam int FIFO_W      = RES_W + 1;

   localparam logic [AVG_W-1:0]   AVG_MAX     = 10'h3E8;
   localparam logic [AVG_W-1:0]   AVG_DEFAULT = 10'h010;
   localparam logic [SCALE_W-1:0] SCALE_ONE   = 16'h0100;
   localparam logic [EN_W-1:0]    EN_BOTH     = 8'h0C;
   localparam logic [EN_W-1:0]    EN_FIRST    = 8'h01;
   localparam logic [EN_W-1:0]    EN_SECOND   = 8'h02;
   localparam logic [EN_W-1:0]    EN_NONE     = 8'h00;
   localparam logic [STEP_W-1:0]  DIV_LAST    = 5'h13;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV  = 2'b01,
      ST_PUSH = 2'b11
   } eng_state_t;

   // bit 0 first channel, bit 1 second; unknown codes disable both
   function automatic logic [1:0] decode_enable(input logic [EN_W-1:0] code);
      case (code)
         EN_BOTH:   decode_enable = 2'h3;
         EN_FIRST:  decode_enable = 2'h1;
         EN_SECOND: decode_enable = 2'h2;
         default:   decode_enable = 2'h0;
      endcase
   endfunction : decode_enable

   // average times unsigned 8.8 factor, fraction dropped
   function automatic logic [RES_W-1:0] scale_result(input logic [CODE_W-1:0]  avg,
                                                     input logic [SCALE_W-1:0] factor);
      logic [CODE_W+SCALE_W-1:0] prod;
      prod = {{SCALE_W{1'b0}}, avg} * {{CODE_W{1'b0}}, factor};
      scale_result = prod[CODE_W+SCALE_W-1:SCALE_FRAC];
   endfunction : scale_result
endpackage : adc_avg_pkg

// ---- design/dual_adc_average_scale.sv ----
// result fifo and the dual converter averaging and scaling top level
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
   parameter int WIDTH = adc_avg_pkg::FIFO_W,
   parameter int DEPTH = adc_avg_pkg::FIFO_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("result_fifo: depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } fifo_state_t;

   fifo_state_t           r;
   fifo_state_t           n;
   logic      [WIDTH-1:0] mem [DEPTH];
   logic                  full;
   logic                  empty;
   logic                  push;
   logic                  pop;

   assign full        = (r.wptr[AW] != r.rptr[AW]) && (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
   assign empty       = (r.wptr == r.rptr);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem[r.rptr[AW-1:0]];
   assign push        = i_in_valid && !full;
   assign pop         = i_out_ready && !empty;

   always_comb begin
      n = r;
      if (push) begin
         n.wptr = r.wptr + 1'b1;
      end
      if (pop) begin
         n.rptr = r.rptr + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[r.wptr[AW-1:0]] <= i_in_data;
      end
   end
endmodule : result_fifo

module dual_adc_average_scale #(
   parameter int TICK_CYCLES = adc_avg_pkg::TICK_CYCLES
) (
   input  wire logic                               i_clk,
   input  wire logic                               i_reset_n,
   input  wire logic [adc_avg_pkg::CODE_W-1:0]     i_analog_in_first,
   input  wire logic [adc_avg_pkg::CODE_W-1:0]     i_analog_in_second,
   input  wire logic                               i_enable_wr,
   input  wire logic [adc_avg_pkg::EN_W-1:0]       i_enable_code,
   input  wire logic                               i_scale_factor_first_wr,
   input  wire logic [adc_avg_pkg::SCALE_W-1:0]    i_scale_factor_first,
   input  wire logic                               i_scale_factor_second_wr,
   input  wire logic [adc_avg_pkg::SCALE_W-1:0]    i_scale_factor_second,
   input  wire logic                               i_average_count_first_wr,
   input  wire logic [adc_avg_pkg::AVG_W-1:0]      i_average_count_first,
   input  wire logic                               i_average_count_second_wr,
   input  wire logic [adc_avg_pkg::AVG_W-1:0]      i_average_count_second,
   output logic                                    o_converter_channel_first_on,
   output logic                                    o_converter_channel_second_on,
   output logic                                    o_sample_tick,
   output logic                                    o_result_valid,
   input  wire logic                               i_result_ready,
   output logic      [adc_avg_pkg::RES_W-1:0]      o_result_data,
   output logic                                    o_result_channel
);
   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [TW-1:0] TICK_MAX = TW'(TICK_CYCLES - 1);

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("dual_adc_average_scale: TICK_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic [TW-1:0]                               tick_cnt;
      logic                                        tick;
      logic [adc_avg_pkg::EN_W-1:0]                enable_code;
      logic [1:0][adc_avg_pkg::SCALE_W-1:0]        scale;
      logic [1:0][adc_avg_pkg::AVG_W-1:0]          avg;
      logic [1:0][adc_avg_pkg::SUM_W-1:0]          acc;
      logic [1:0][adc_avg_pkg::AVG_W-1:0]          cnt;
      logic [1:0]                                  pend;
      logic [1:0][adc_avg_pkg::SUM_W-1:0]          pend_sum;
      logic [1:0][adc_avg_pkg::AVG_W-1:0]          pend_n;
      logic [1:0][adc_avg_pkg::SCALE_W-1:0]        pend_fac;
      adc_avg_pkg::eng_state_t                     st;
      logic                                        chan;
      logic [adc_avg_pkg::STEP_W-1:0]              step;
      logic [adc_avg_pkg::SUM_W:0]                 rem;
      logic [adc_avg_pkg::SUM_W-1:0]               dvd;
      logic [adc_avg_pkg::AVG_W-1:0]               den;
      logic [adc_avg_pkg::SCALE_W-1:0]             fac;
   } core_state_t;

   core_state_t                          r;
   core_state_t                          n;
   logic      [1:0]                      en;
   logic                                 fifo_in_ready;
   logic                                 push_valid;
   logic      [adc_avg_pkg::RES_W-1:0]   push_data;
   logic      [adc_avg_pkg::FIFO_W-1:0]  fifo_out;

   assign en                            = adc_avg_pkg::decode_enable(r.enable_code);
   assign o_converter_channel_first_on  = en[0];
   assign o_converter_channel_second_on = en[1];
   assign o_sample_tick                 = r.tick;
   assign push_valid                    = (r.st == adc_avg_pkg::ST_PUSH);
   assign push_data = adc_avg_pkg::scale_result(r.dvd[adc_avg_pkg::CODE_W-1:0],
                                                r.fac);
   assign o_result_data    = fifo_out[adc_avg_pkg::RES_W-1:0];
   assign o_result_channel = fifo_out[adc_avg_pkg::RES_W];

   always_comb begin
      logic [1:0]                        restart;
      logic [adc_avg_pkg::CODE_W-1:0]    sample;
      logic [adc_avg_pkg::SUM_W-1:0]     sum;
      logic [adc_avg_pkg::SUM_W:0]       rem_sh;
      logic                              take;
      logic                              pick;
      restart = 2'h0;
      sample  = '0;
      sum     = '0;
      rem_sh  = '0;
      take    = 1'b0;
      pick    = 1'b0;
      n       = r;
      // free-running divider, never touched by settings
      n.tick     = (r.tick_cnt == TICK_MAX);
      n.tick_cnt = n.tick ? '0 : r.tick_cnt + 1'b1;
      // each setting has its own strobe
      if (i_enable_wr) begin
         n.enable_code = i_enable_code;
         restart       = 2'h3;
      end
      if (i_scale_factor_first_wr && i_scale_factor_first != '0) begin
         n.scale[0] = i_scale_factor_first;
      end
      if (i_scale_factor_second_wr && i_scale_factor_second != '0) begin
         n.scale[1] = i_scale_factor_second;
      end
      if (i_average_count_first_wr && i_average_count_first != '0
          && i_average_count_first <= adc_avg_pkg::AVG_MAX) begin
         n.avg[0]   = i_average_count_first;
         restart[0] = 1'b1;
      end
      if (i_average_count_second_wr && i_average_count_second != '0
          && i_average_count_second <= adc_avg_pkg::AVG_MAX) begin
         n.avg[1]   = i_average_count_second;
         restart[1] = 1'b1;
      end
      // shared divide and scale engine
      unique case (r.st)
         adc_avg_pkg::ST_IDLE: begin
            if (r.pend[0] || r.pend[1]) begin
               take = 1'b1;
               pick = !r.pend[0];
            end
         end
         adc_avg_pkg::ST_DIV: begin
            rem_sh = {r.rem[adc_avg_pkg::SUM_W-1:0], r.dvd[adc_avg_pkg::SUM_W-1]};
            if (rem_sh >= {{(adc_avg_pkg::SUM_W + 1 - adc_avg_pkg::AVG_W){1'b0}}, r.den}) begin
               n.rem = rem_sh - {{(adc_avg_pkg::SUM_W + 1 - adc_avg_pkg::AVG_W){1'b0}}, r.den};
               n.dvd = {r.dvd[adc_avg_pkg::SUM_W-2:0], 1'b1};
            end else begin
               n.rem = rem_sh;
               n.dvd = {r.dvd[adc_avg_pkg::SUM_W-2:0], 1'b0};
            end
            n.step = r.step + 1'b1;
            if (r.step == adc_avg_pkg::DIV_LAST) begin
               n.st = adc_avg_pkg::ST_PUSH;
            end
         end
         adc_avg_pkg::ST_PUSH: begin
            if (fifo_in_ready) begin
               n.st = adc_avg_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = adc_avg_pkg::ST_IDLE;
         end
      endcase
      if (take) begin
         n.pend[pick] = 1'b0;
         n.dvd        = r.pend_sum[pick];
         n.den        = r.pend_n[pick];
         n.fac        = r.pend_fac[pick];
         n.rem        = '0;
         n.step       = '0;
         n.chan       = pick;
         n.st         = adc_avg_pkg::ST_DIV;
      end
      // accumulation; a new window end overrides the engine's clear
      for (int c = 0; c < 2; c++) begin
         sample = (c == 0) ? i_analog_in_first : i_analog_in_second;
         sum    = r.acc[c] + {{(adc_avg_pkg::SUM_W - adc_avg_pkg::CODE_W){1'b0}}, sample};
         if (restart[c] || !en[c]) begin
            n.acc[c] = '0;
            n.cnt[c] = '0;
         end else if (r.tick) begin
            if (r.cnt[c] + 1'b1 == r.avg[c]) begin
               n.pend[c]     = 1'b1;
               n.pend_sum[c] = sum;
               n.pend_n[c]   = r.avg[c];
               n.pend_fac[c] = r.scale[c];
               n.acc[c]      = '0;
               n.cnt[c]      = '0;
            end else begin
               n.acc[c] = sum;
               n.cnt[c] = r.cnt[c] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         r             <= '0;
         r.enable_code <= adc_avg_pkg::EN_NONE;
         r.scale       <= {adc_avg_pkg::SCALE_ONE, adc_avg_pkg::SCALE_ONE};
         r.avg         <= {adc_avg_pkg::AVG_DEFAULT, adc_avg_pkg::AVG_DEFAULT};
         r.st          <= adc_avg_pkg::ST_IDLE;
      end else begin
         r <= n;
      end
   end

   result_fifo #(
      .WIDTH (adc_avg_pkg::FIFO_W),
      .DEPTH (adc_avg_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (push_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({r.chan, push_data}),
      .o_out_valid (o_result_valid),
      .i_out_ready (i_result_ready),
      .o_out_data  (fifo_out)
   );

   sequence div_start_s;
      $rose(r.st == adc_avg_pkg::ST_DIV);
   endsequence

   sequence div_run_s;
      (r.st == adc_avg_pkg::ST_DIV) [*8];
   endsequence

   tick_period_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      r.tick |-> $past(r.tick_cnt) == TICK_MAX && r.tick_cnt == '0)
      else $error("sample tick off period");

   rate_kept_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_average_count_first_wr && r.tick_cnt != TICK_MAX) |=>
         r.tick_cnt == $past(r.tick_cnt) + 1'b1)
      else $error("count write disturbed sample rate");

   reset_values_a: assert property (@(posedge i_clk)
      !i_reset_n |=> r.enable_code == adc_avg_pkg::EN_NONE && en == 2'h0
         && r.scale[0] == adc_avg_pkg::SCALE_ONE && r.scale[1] == adc_avg_pkg::SCALE_ONE
         && r.avg[0] == adc_avg_pkg::AVG_DEFAULT && r.avg[1] == adc_avg_pkg::AVG_DEFAULT)
      else $error("wrong values after reset");

   enable_map_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (r.enable_code == adc_avg_pkg::EN_FIRST) |->
         o_converter_channel_first_on && !o_converter_channel_second_on)
      else $error("enable code 1 decoded wrongly");

   window_close_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (r.tick && en[1] && !restart_any(1) && r.cnt[1] + 1'b1 == r.avg[1]) |=>
         r.pend[1] && r.cnt[1] == '0 && r.pend_n[1] == $past(r.avg[1]))
      else $error("finished window not handed over");

   restart_window_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_average_count_second_wr && i_average_count_second != '0
       && i_average_count_second <= adc_avg_pkg::AVG_MAX) |=>
         r.cnt[1] == '0 && r.acc[1] == '0)
      else $error("partial window kept after count change");

   idle_channel_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!en[0] && !i_enable_wr) |=> r.acc[0] == '0 && !$rose(r.pend[0]))
      else $error("disabled channel accumulated");

   scale_only_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_scale_factor_first_wr && !i_scale_factor_second_wr && !i_enable_wr
       && !i_average_count_first_wr && !i_average_count_second_wr) |=>
         $stable(r.scale[1]) && $stable(r.enable_code) && $stable(r.avg))
      else $error("one setting write changed another");

   zero_factor_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> r.scale[0] != '0 && r.scale[1] != '0)
      else $error("calibration factor became zero");

   div_length_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      div_start_s |-> div_run_s ##13 (r.st == adc_avg_pkg::ST_PUSH))
      else $error("divide did not take twenty cycles");

   full_scale_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      push_valid |-> push_data <= adc_avg_pkg::scale_result(10'h3FF, r.fac))
      else $error("result above scaled full scale");

   function automatic logic restart_any(input int c);
      restart_any = i_enable_wr || (c == 1 && i_average_count_second_wr);
   endfunction : restart_any
endmodule : dual_adc_average_scale

`default_nettype wire

// ---- verif/analog_source_model.sv ----
// analogue source model driving both converter input codes
`timescale 1ns/1ps
`default_nettype none

module analog_source_model (
   input  wire logic                           i_clk,
   input  wire logic                           i_full_scale,
   output logic      [adc_avg_pkg::CODE_W-1:0] o_analog_in_first,
   output logic      [adc_avg_pkg::CODE_W-1:0] o_analog_in_second
);
   initial begin
      o_analog_in_first  = 10'h000;
      o_analog_in_second = 10'h000;
   end

   // voltage wanders every cycle; full scale pins both at the top code
   always @(posedge i_clk) begin
      #1;
      o_analog_in_first  <= i_full_scale ? 10'h3FF : 10'($urandom_range(0, 1023));
      o_analog_in_second <= i_full_scale ? 10'h3FF : 10'($urandom_range(0, 1023));
   end
endmodule : analog_source_model

`default_nettype wire

// ---- verif/dual_adc_average_scale_test.sv ----
// self-checking bench for the dual converter averaging and scaling block
`timescale 1ns/1ps
`default_nettype none

module dual_adc_average_scale_test;
   localparam int TICK  = 40;
   localparam int LIMIT = 60000;

   logic                               clk;
   logic                               rst_n;
   logic [adc_avg_pkg::CODE_W-1:0]     a1;
   logic [adc_avg_pkg::CODE_W-1:0]     a2;
   logic                               en_wr;
   logic [adc_avg_pkg::EN_W-1:0]       en_code;
   logic                               f1_wr;
   logic [adc_avg_pkg::SCALE_W-1:0]    f1;
   logic                               f2_wr;
   logic [adc_avg_pkg::SCALE_W-1:0]    f2;
   logic                               c1_wr;
   logic [adc_avg_pkg::AVG_W-1:0]      c1;
   logic                               c2_wr;
   logic [adc_avg_pkg::AVG_W-1:0]      c2;
   logic                               on1;
   logic                               on2;
   logic                               tick;
   logic                               rv;
   logic                               rr;
   logic [adc_avg_pkg::RES_W-1:0]      rd;
   logic                               rch;
   logic                               full_scale;
   logic                               m_tick;
   logic [1:0]                         m_en;
   logic [1:0]                         m_rs;
   logic [18:0]                        exp_q[$];
   logic [7:0]                         codes[5] = '{8'h0C, 8'h01, 8'h02, 8'h00, 8'h5A};
   int                                 m_cnt, m_fac[2], m_avg[2], m_sum[2], m_n[2];
   int                                 tick_seen, cycles, rdy_mode;
   int                                 error_cnt, n_compared;

   dual_adc_average_scale #(.TICK_CYCLES(TICK)) dut (
      .i_clk(clk), .i_reset_n(rst_n),
      .i_analog_in_first(a1), .i_analog_in_second(a2),
      .i_enable_wr(en_wr), .i_enable_code(en_code),
      .i_scale_factor_first_wr(f1_wr), .i_scale_factor_first(f1),
      .i_scale_factor_second_wr(f2_wr), .i_scale_factor_second(f2),
      .i_average_count_first_wr(c1_wr), .i_average_count_first(c1),
      .i_average_count_second_wr(c2_wr), .i_average_count_second(c2),
      .o_converter_channel_first_on(on1), .o_converter_channel_second_on(on2),
      .o_sample_tick(tick), .o_result_valid(rv), .i_result_ready(rr),
      .o_result_data(rd), .o_result_channel(rch)
   );

   analog_source_model src (
      .i_clk(clk), .i_full_scale(full_scale),
      .o_analog_in_first(a1), .o_analog_in_second(a2)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic fail(input string msg);
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
   endtask : fail

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // reference model of windows, settings and the result stream
   always @(posedge clk) begin
      cycles++;
      if (cycles >= LIMIT) begin
         fail("timeout");
         end_of_test();
      end
      if (!rst_n) begin
         m_cnt = 0;
         m_tick = 1'b0;
         m_en = 2'b00;
         exp_q.delete();
         for (int c = 0; c < 2; c++) begin
            m_fac[c] = 256;
            m_avg[c] = 16;
            m_sum[c] = 0;
            m_n[c] = 0;
         end
      end else begin
         n_compared += 2;
         if (tick !== m_tick) fail("sample tick off its period");
         if ({on2, on1} !== m_en) fail("channel enable state wrong");
         if (rv === 1'b1 && rr === 1'b1) begin
            n_compared++;
            if (exp_q.size() == 0) fail("unexpected result");
            else if ({rch, rd} !== exp_q.pop_front()) fail("result word wrong");
         end
         // a restarting write on a tick edge drops that sample
         m_rs[0] = en_wr || (c1_wr && c1 >= 10'h001 && c1 <= 10'h3E8);
         m_rs[1] = en_wr || (c2_wr && c2 >= 10'h001 && c2 <= 10'h3E8);
         if (m_tick) begin
            tick_seen++;
            for (int c = 0; c < 2; c++) begin
               if (m_en[c] && !m_rs[c]) begin
                  m_sum[c] += (c == 0) ? int'(a1) : int'(a2);
                  m_n[c]++;
                  if (m_n[c] == m_avg[c]) begin
                     exp_q.push_back({1'(c), 18'(((m_sum[c] / m_avg[c]) * m_fac[c]) >> 8)});
                     m_sum[c] = 0;
                     m_n[c] = 0;
                  end
               end
            end
         end
         if (en_wr) begin
            case (en_code)
               8'h0C:   m_en = 2'b11;
               8'h01:   m_en = 2'b01;
               8'h02:   m_en = 2'b10;
               default: m_en = 2'b00;
            endcase
            m_sum = '{0, 0};
            m_n = '{0, 0};
         end
         if (f1_wr && f1 != 16'h0000) m_fac[0] = int'(f1);
         if (f2_wr && f2 != 16'h0000) m_fac[1] = int'(f2);
         if (c1_wr && c1 >= 10'h001 && c1 <= 10'h3E8) begin
            m_avg[0] = int'(c1);
            m_sum[0] = 0;
            m_n[0] = 0;
         end
         if (c2_wr && c2 >= 10'h001 && c2 <= 10'h3E8) begin
            m_avg[1] = int'(c2);
            m_sum[1] = 0;
            m_n[1] = 0;
         end
         m_tick = (m_cnt == TICK - 1);
         m_cnt = m_tick ? 0 : m_cnt + 1;
      end
   end

   // consumer: 0 stalls, 1 random, 2 always ready
   always @(posedge clk) begin
      #1;
      rr = (rdy_mode == 2) || (rdy_mode == 1 && $urandom_range(0, 1) == 1);
   end

   // one setting write: 0 enable, 1/2 factors, 3/4 counts
   task automatic put(input int which, input logic [15:0] v);
      @(posedge clk);
      #1;
      case (which)
         0: begin en_wr = 1'b1; en_code = v[7:0]; end
         1: begin f1_wr = 1'b1; f1 = v; end
         2: begin f2_wr = 1'b1; f2 = v; end
         3: begin c1_wr = 1'b1; c1 = v[9:0]; end
         default: begin c2_wr = 1'b1; c2 = v[9:0]; end
      endcase
      @(posedge clk);
      #1;
      {en_wr, f1_wr, f2_wr, c1_wr, c2_wr} = 5'h00;
   endtask : put

   task automatic wait_ticks(input int n);
      int target;
      target = tick_seen + n;
      while (tick_seen < target) @(negedge clk);
   endtask : wait_ticks

   task automatic drain(input string name);
      int k;
      rdy_mode = 2;
      k = 0;
      while ((exp_q.size() != 0 || rv !== 1'b0) && k < 3000) begin
         @(negedge clk);
         k++;
      end
      n_compared++;
      if (exp_q.size() != 0) fail("results missing");
      $display("test %s done, errors %0d", name, error_cnt);
   endtask : drain

   initial begin
      void'($urandom(24377));
      {rst_n, en_wr, f1_wr, f2_wr, c1_wr, c2_wr, full_scale} = 7'h00;
      {en_code, f1, f2, c1, c2} = '0;
      {cycles, tick_seen, error_cnt, n_compared} = '0;
      rdy_mode = 1;
      rr = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      wait_ticks(3);
      put(0, 16'h000C);
      wait_ticks(17);
      drain("defaults");
      put(3, 16'h0001);
      put(4, 16'h0002);
      foreach (codes[i]) begin
         put(0, {8'h00, codes[i]});
         wait_ticks(4);
      end
      drain("enable codes");
      full_scale = 1'b1;
      put(1, 16'h0033);
      put(2, 16'h0000);
      put(2, 16'($urandom_range(1, 65535)));
      put(0, 16'h000C);
      wait_ticks(6);
      put(1, 16'hFFFF);
      wait_ticks(2);
      drain("scale factors");
      full_scale = 1'b0;
      rdy_mode = 1;
      put(3, 16'h0000);
      put(4, 16'h03E9);
      put(3, 16'h0008);
      wait_ticks(3);
      put(3, 16'h0008);
      wait_ticks(2);
      put(0, 16'h000C);
      wait_ticks(10);
      put(3, 16'h03E8);
      put(4, 16'h0007);
      wait_ticks(1001);
      drain("average counts");
      rdy_mode = 0;
      put(0, 16'h0000);
      put(3, 16'h0001);
      put(0, 16'h0001);
      wait_ticks(9);
      put(0, 16'h0000);
      repeat (100) @(negedge clk);
      n_compared++;
      if (rv !== 1'b1) fail("full buffer lost its words");
      drain("full buffer");
      put(0, 16'h000C);
      wait_ticks(5);
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      wait_ticks(3);
      put(0, 16'h0002);
      wait_ticks(17);
      drain("second reset");
      end_of_test();
   end
endmodule : dual_adc_average_scale_test

`default_nettype wire
